// [design/ahs_homing.sv]
// Axis homing sequencer with object-dictionary access and switch, limit and index inputs.
`timescale 1ns/1ns
`include "ahs_cfg.svh"
module ahs_homing
  import ahs_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        od_wr_en,
  input  wire logic        od_rd_en,
  input  wire logic [15:0] od_index,
  input  wire logic [7:0]  od_sub,
  input  wire logic [31:0] od_wdata,
  output logic      [31:0] od_rdata,
  output logic             od_rvalid,
  input  wire logic        neg_limit,
  input  wire logic        pos_limit,
  input  wire logic        home_sw,
  input  wire logic        index_pulse,
  input  wire logic [31:0] position,
  output logic             move_en,
  output logic             dir_right,
  output logic      [31:0] speed_cmd,
  output logic      [31:0] accel_cmd,
  output logic      [31:0] home_pos,
  output logic      [31:0] zero_pos,
  output logic      [15:0] statusword
);

  // ****************************************************************
  // Method decoding
  // ****************************************************************

  // Turns a method code into signal, sides and index use.
  function automatic ahs_meth_s decode(input logic signed [7:0] code);
    ahs_meth_s   r;
    logic signed [7:0] m;
    logic [3:0]  b;
    logic [13:0] fr_tbl;
    logic [13:0] wa_tbl;
    r = '0;
    fr_tbl = `AHS_FINAL_RIGHT;
    wa_tbl = `AHS_WANT_ACTIVE;
    m = (code < 0) ? -code : code;
    r.use_idx = (code > 0);
    if (m > `AHS_M_NOIDX_BASE && m <= `AHS_M_NOIDX_LAST)
    begin
      m = m - `AHS_M_NOIDX_BASE;
      r.use_idx = 1'b0;
    end
    b = 4'(m - 8'sd1);
    if (m >= `AHS_M_NEG_LIM && m <= `AHS_M_LAST_SW)
    begin
      r.valid       = 1'b1;
      r.kind        = AHS_K_SWITCH;
      r.sig         = (m == `AHS_M_NEG_LIM) ? AHS_SIG_NEG :
                      (m == `AHS_M_POS_LIM) ? AHS_SIG_POS : AHS_SIG_HOME;
      r.final_right = fr_tbl[b];
      r.want        = wa_tbl[b];
      r.momentary   = (m >= `AHS_M_MOM_FIRST);
      r.init_right  = (m < `AHS_M_MOM_LEFT);
    end
    else if ((m == `AHS_M_IDX_NEG || m == `AHS_M_IDX_POS) && code > 0)
    begin
      r.valid       = 1'b1;
      r.kind        = AHS_K_INDEX;
      r.final_right = (m == `AHS_M_IDX_POS);
      r.use_idx     = 1'b1;
    end
    else if (m == `AHS_M_CURRENT && code > 0)
    begin
      r.valid = 1'b1;
      r.kind  = AHS_K_CURRENT;
    end
    return r;
  endfunction

  // Picks the level of the selected homing signal.
  function automatic logic sel_sig(input ahs_sig_e s, input logic n, input logic p,
                                   input logic h);
    return (s == AHS_SIG_NEG) ? n : (s == AHS_SIG_POS) ? p : h;
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************

  ahs_state_s q;
  ahs_state_s d;
  logic       wr_ctrl;
  logic       start;
  logic       abort;
  logic       level;
  logic       lim_hit;
  logic       halt;
  logic       stepping;

  // Control word edges are judged against the stored word at the write.
  assign wr_ctrl  = od_wr_en && od_index == `AHS_IDX_CTRL;
  assign start    = wr_ctrl && od_wdata[`AHS_CW_START] && !q.ctrl[`AHS_CW_START];
  assign abort    = wr_ctrl && !od_wdata[`AHS_CW_START] && q.ctrl[`AHS_CW_START];
  assign halt     = q.ctrl[`AHS_CW_HALT];
  assign level    = sel_sig(q.md.sig, neg_limit, pos_limit, home_sw);
  assign lim_hit  = q.dir ? pos_limit : neg_limit;
  assign stepping = !halt && !abort;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************

  // One process updates registers, sequencer and read data.
  always_comb
  begin
    ahs_meth_s md;
    logic      finish;
    d      = q;
    md     = decode(q.method);
    finish = 1'b0;
    d.rvalid = od_rd_en;
    d.rdata  = `AHS_RST_WORD;
    if (od_rd_en)
    begin
      case (od_index)
        `AHS_IDX_CTRL:   d.rdata = {16'h0000, q.ctrl};
        `AHS_IDX_STAT:   d.rdata = {16'h0000, statusword};
        `AHS_IDX_OFFSET: d.rdata = q.offset;
        `AHS_IDX_METHOD: d.rdata = {{24{q.method[7]}}, q.method};
        `AHS_IDX_ACCEL:  d.rdata = q.accel;
        `AHS_IDX_SPEEDS:
        begin
          if (od_sub == `AHS_SUB_COUNT)
            d.rdata = `AHS_SPEED_COUNT;
          else if (od_sub == `AHS_SUB_SW)
            d.rdata = q.spd_sw;
          else if (od_sub == `AHS_SUB_ZERO)
            d.rdata = q.spd_zero;
        end
        default:         d.rdata = `AHS_RST_WORD;
      endcase
    end
    if (od_wr_en)
    begin
      case (od_index)
        `AHS_IDX_CTRL:   d.ctrl = od_wdata[15:0];
        `AHS_IDX_OFFSET: d.offset = od_wdata;
        `AHS_IDX_METHOD: d.method = od_wdata[7:0];
        `AHS_IDX_ACCEL:  d.accel = od_wdata;
        `AHS_IDX_SPEEDS:
        begin
          if (od_sub == `AHS_SUB_SW)
            d.spd_sw = od_wdata;
          else if (od_sub == `AHS_SUB_ZERO)
            d.spd_zero = od_wdata;
        end
        default:         d.method = d.method;
      endcase
    end
    case (q.st)
      AHS_IDLE:
      begin
        if (start)
        begin
          d.md       = md;
          d.attained = 1'b0;
          d.error    = 1'b0;
          if (q.method == `AHS_M_NONE)
            d.st = AHS_IDLE;
          else if (!md.valid)
            d.error = 1'b1;
          else if (md.kind == AHS_K_CURRENT)
            finish = 1'b1;
          else if (md.kind == AHS_K_INDEX)
          begin
            d.st  = AHS_INDEX;
            d.dir = md.final_right;
          end
          else if (md.momentary && !sel_sig(md.sig, neg_limit, pos_limit, home_sw))
          begin
            d.st  = AHS_SEEK;
            d.dir = md.init_right;
          end
          else if (sel_sig(md.sig, neg_limit, pos_limit, home_sw) == md.want)
          begin
            d.st  = AHS_ALIGN;
            d.dir = !md.final_right;
          end
          else
          begin
            d.st  = AHS_APPROACH;
            d.dir = md.final_right;
          end
        end
      end
      AHS_SEEK:
      begin
        if (stepping && level)
        begin
          d.st  = q.md.want ? AHS_ALIGN : AHS_APPROACH;
          d.dir = q.md.want ? !q.md.final_right : q.md.final_right;
        end
        else if (stepping && lim_hit)
          d.dir = !q.dir;
      end
      AHS_ALIGN:
      begin
        if (stepping && level != q.md.want)
        begin
          d.st  = AHS_APPROACH;
          d.dir = q.md.final_right;
        end
      end
      AHS_APPROACH:
      begin
        if (stepping && level == q.md.want)
        begin
          if (q.md.use_idx)
            d.st = AHS_INDEX;
          else
            finish = 1'b1;
        end
      end
      AHS_INDEX:
      begin
        if (stepping && index_pulse)
          finish = 1'b1;
      end
      default: d.st = AHS_IDLE;
    endcase
    if (finish)
    begin
      d.st       = AHS_IDLE;
      d.home_pos = position;
      d.zero_pos = position + q.offset;
      d.attained = 1'b1;
    end
    if (abort)
      d.st = AHS_IDLE;
    d.spd  = (d.st == AHS_INDEX) ? d.spd_zero : d.spd_sw;
    d.move = (d.st != AHS_IDLE) && !d.ctrl[`AHS_CW_HALT];
  end

  // ****************************************************************
  // Registers
  // ****************************************************************

  // Synchronous reset; acceleration has no printed default and clears too.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign dir_right  = q.dir;
  assign move_en    = q.move;
  assign speed_cmd  = q.spd;
  assign accel_cmd  = q.accel;
  assign home_pos   = q.home_pos;
  assign zero_pos   = q.zero_pos;
  assign od_rdata   = q.rdata;
  assign od_rvalid  = q.rvalid;

  // Status bits; reached also covers a halted, stopped axis.
  always_comb
  begin
    statusword = 16'h0000;
    statusword[`AHS_SW_ATTAINED] = q.attained;
    statusword[`AHS_SW_ERROR]    = q.error;
    statusword[`AHS_SW_REACHED]  = q.attained || (halt && !q.move);
  end

  // ****************************************************************
  // Checks
  // ****************************************************************

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_start(logic signed [7:0] m);
    q.st == AHS_IDLE && start && q.method == m;
  endsequence

  property p_count;
    od_rd_en && od_index == `AHS_IDX_SPEEDS && od_sub == `AHS_SUB_COUNT
      |=> od_rvalid && od_rdata == `AHS_SPEED_COUNT;
  endproperty
  a_count: assert property (p_count) else $error("entry count not 2");

  property p_accel;
    od_wr_en && od_index == `AHS_IDX_ACCEL |=> accel_cmd == $past(od_wdata);
  endproperty
  a_accel: assert property (p_accel) else $error("acceleration not taken");

  property p_reserved;
    s_start(8'sd15) or s_start(8'sd31) |=> statusword[`AHS_SW_ERROR] && !move_en;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code not refused");

  property p_current;
    s_start(`AHS_M_CURRENT) |=> statusword[`AHS_SW_ATTAINED] && !move_en
      && home_pos == $past(position);
  endproperty
  a_current: assert property (p_current) else $error("method 35 wrong");

  property p_m1_left;
    s_start(`AHS_M_NEG_LIM) ##0 (!neg_limit && !od_wdata[`AHS_CW_HALT])
      |=> move_en && !dir_right;
  endproperty
  a_m1_left: assert property (p_m1_left) else $error("method 1 not leftward");

  property p_idx_speed;
    q.st == AHS_INDEX |-> speed_cmd == q.spd_zero;
  endproperty
  a_idx_speed: assert property (p_idx_speed) else $error("index speed wrong");

  property p_abort;
    abort |=> !move_en ##1 !move_en;
  endproperty
  a_abort: assert property (p_abort) else $error("abort did not stop");

  property p_halt;
    halt && $stable(q.ctrl) |-> !move_en;
  endproperty
  a_halt: assert property (p_halt) else $error("halt ignored");

  property p_zero;
    $rose(q.attained) |-> zero_pos == home_pos + q.offset;
  endproperty
  a_zero: assert property (p_zero) else $error("zero position wrong");

endmodule

// [design/ahs_cfg.svh]
// Constants for the axis homing sequencer: object indices, fields, reset values, method table.
`ifndef AHS_CFG_SVH
`define AHS_CFG_SVH
`define AHS_IDX_CTRL     16'h6040
`define AHS_IDX_STAT     16'h6041
`define AHS_IDX_OFFSET   16'h607C
`define AHS_IDX_METHOD   16'h6098
`define AHS_IDX_SPEEDS   16'h6099
`define AHS_IDX_ACCEL    16'h609A
`define AHS_SUB_COUNT    8'h00
`define AHS_SUB_SW       8'h01
`define AHS_SUB_ZERO     8'h02
`define AHS_SPEED_COUNT  32'h0000_0002
`define AHS_RST_WORD     32'h0000_0000
`define AHS_CW_START     4
`define AHS_CW_HALT      8
`define AHS_SW_REACHED   10
`define AHS_SW_ATTAINED  12
`define AHS_SW_ERROR     13
`define AHS_M_NONE       8'sd0
`define AHS_M_NEG_LIM    8'sd1
`define AHS_M_POS_LIM    8'sd2
`define AHS_M_LAST_SW    8'sd14
`define AHS_M_MOM_FIRST  8'sd7
`define AHS_M_MOM_LEFT   8'sd11
`define AHS_M_NOIDX_BASE 8'sd16
`define AHS_M_NOIDX_LAST 8'sd30
`define AHS_M_IDX_NEG    8'sd33
`define AHS_M_IDX_POS    8'sd34
`define AHS_M_CURRENT    8'sd35
// Bit m-1 set: method m makes its final approach rightward.
`define AHS_FINAL_RIGHT  14'h1699
// Bit m-1 set: method m seeks the edge where the signal becomes active.
`define AHS_WANT_ACTIVE  14'h19A8
`endif

// [design/ahs_pkg.sv]
// Types shared by the axis homing sequencer.
package ahs_pkg;
  typedef enum logic [2:0] {AHS_IDLE, AHS_SEEK, AHS_ALIGN, AHS_APPROACH, AHS_INDEX} ahs_state_e;
  typedef enum logic [1:0] {AHS_SIG_NEG, AHS_SIG_POS, AHS_SIG_HOME} ahs_sig_e;
  typedef enum logic [1:0] {AHS_K_SWITCH, AHS_K_INDEX, AHS_K_CURRENT} ahs_kind_e;
  typedef struct packed {
    logic      valid;
    ahs_kind_e kind;
    ahs_sig_e  sig;
    logic      final_right;
    logic      want;
    logic      use_idx;
    logic      momentary;
    logic      init_right;
  } ahs_meth_s;
  typedef struct packed {
    ahs_state_e  st;
    ahs_meth_s   md;
    logic [15:0] ctrl;
    logic [7:0]  method;
    logic [31:0] spd_sw;
    logic [31:0] spd_zero;
    logic [31:0] accel;
    logic [31:0] offset;
    logic [31:0] home_pos;
    logic [31:0] zero_pos;
    logic [31:0] spd;
    logic [31:0] rdata;
    logic        rvalid;
    logic        attained;
    logic        error;
    logic        dir;
    logic        move;
  } ahs_state_s;
endpackage

// [verification/ahs_axis_model.sv]
// Axis stand-in that moves on command and makes the limit, home and index signals.
`timescale 1ns/1ns
module ahs_axis_model
#(
  parameter int NEG_END = 0,
  parameter int POS_END = 200,
  parameter int HOME_AT = 150,
  parameter int IDX_MOD = 16,
  parameter int IDX_AT  = 8
)
(
  input  wire logic        clk_sys,
  input  wire logic        move_en,
  input  wire logic        dir_right,
  input  wire logic        load,
  input  wire logic [31:0] load_pos,
  output logic      [31:0] position,
  output logic             neg_limit,
  output logic             pos_limit,
  output logic             home_sw,
  output logic             index_pulse
);
  int p;

  // ****************
  // Axis motion
  // ****************
  // One count per cycle, so no switch edge or index mark is ever skipped.
  // right raises count
  always_ff @(posedge clk_sys)
  begin
    if (load)
      position <= load_pos;
    else if (move_en)
      position <= dir_right ? position + 32'h0000_0001 : position - 32'h0000_0001;
  end

  // Switch levels follow position; the index mark is off the negative limit edge but falls on the positive one at 200.
  // four signal sources
  always_comb
  begin
    p = $signed(position);
    neg_limit = p < NEG_END;
    pos_limit = p >= POS_END;
    home_sw = p >= HOME_AT;
    index_pulse = (((p % IDX_MOD) + IDX_MOD) % IDX_MOD) == IDX_AT;
  end
endmodule

// [verification/axis_homing_sequencer_tb.sv]
// Self-checking bench for the homing sequencer driven through its object port.
`timescale 1ns/1ns
`include "ahs_cfg.svh"
`define TB_CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin err_total++; \
  $display("unexpected %s exp %0h got %0h", nm, ex, gt); end end
module axis_homing_sequencer_tb;
  logic        clk_sys  = 1'b0;
  logic        sys_rst  = 1'b1;
  logic        od_wr_en = 1'b0;
  logic        od_rd_en = 1'b0;
  logic [15:0] od_index = 16'h0000;
  logic [7:0]  od_sub   = 8'h00;
  logic [31:0] od_wdata = 32'h0000_0000;
  logic        ld       = 1'b1;
  logic [31:0] od_rdata, position, speed_cmd, accel_cmd, home_pos, zero_pos, got, last_spd;
  logic        od_rvalid, neg_limit, pos_limit, home_sw, index_pulse, move_en, dir_right;
  logic [15:0] statusword;
  int          n_compared = 0;
  int          err_total  = 0;
  int          cyc        = 0;
  // Object table: index, sub-index, value written, value expected back.
  logic [15:0] r_idx [8] = '{`AHS_IDX_SPEEDS, `AHS_IDX_SPEEDS, `AHS_IDX_SPEEDS, `AHS_IDX_ACCEL,
                             `AHS_IDX_METHOD, `AHS_IDX_OFFSET, 16'h1234, `AHS_IDX_STAT};
  logic [7:0]  r_sub [8] = '{8'h00, 8'h01, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [31:0] w_val [8] = '{32'h0000_0005, 32'h0000_0064, 32'h0000_000A, 32'h0000_1234,
                             32'h0000_0000, 32'hFFFF_FFFB, 32'h0000_DEAD, 32'h0000_3000};
  logic [31:0] r_new [8] = '{32'h0000_0002, 32'h0000_0064, 32'h0000_000A, 32'h0000_1234,
                             32'h0000_0000, 32'hFFFF_FFFB, 32'h0000_0000, 32'h0000_0000};
  // Method table: code, first direction, home position, last speed (0 skips speed checks).
  logic [7:0]  m_code [9] = '{8'h01, 8'h02, 8'h21, 8'h22, 8'h23, 8'h11, 8'hFF, 8'h03, 8'h0D};
  logic        m_dir  [9] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
  logic [31:0] m_home [9] = '{32'h0000_0008, 32'h0000_00B8, 32'h0000_0058, 32'h0000_0068,
                              32'h0000_0064, 32'h0000_0000, 32'h0000_0000, 32'h0000_0088,
                              32'h0000_0098};
  logic [31:0] m_last [9] = '{32'h0000_000A, 32'h0000_000A, 32'h0000_0000, 32'h0000_0000,
                              32'h0000_0000, 32'h0000_0064, 32'h0000_0064, 32'h0000_000A,
                              32'h0000_000A};
  logic [7:0]  m_bad  [5] = '{8'h0F, 8'h10, 8'h1F, 8'h20, 8'h24};

  always #2 clk_sys = ~clk_sys;

  ahs_homing DUT
  (
    .clk_sys     (clk_sys),
    .sys_rst     (sys_rst),
    .od_wr_en    (od_wr_en),
    .od_rd_en    (od_rd_en),
    .od_index    (od_index),
    .od_sub      (od_sub),
    .od_wdata    (od_wdata),
    .od_rdata    (od_rdata),
    .od_rvalid   (od_rvalid),
    .neg_limit   (neg_limit),
    .pos_limit   (pos_limit),
    .home_sw     (home_sw),
    .index_pulse (index_pulse),
    .position    (position),
    .move_en     (move_en),
    .dir_right   (dir_right),
    .speed_cmd   (speed_cmd),
    .accel_cmd   (accel_cmd),
    .home_pos    (home_pos),
    .zero_pos    (zero_pos),
    .statusword  (statusword)
  );

  ahs_axis_model axis
  (
    .clk_sys     (clk_sys),
    .move_en     (move_en),
    .dir_right   (dir_right),
    .load        (ld),
    .load_pos    (32'h0000_0064),
    .position    (position),
    .neg_limit   (neg_limit),
    .pos_limit   (pos_limit),
    .home_sw     (home_sw),
    .index_pulse (index_pulse)
  );

  // ****************
  // Access tasks
  // ****************
  // A request is held across exactly one taking edge, then dropped.
  task automatic od_wr(input logic [15:0] idx, input logic [7:0] sb, input logic [31:0] d);
    @(posedge clk_sys);
    #1;
    od_wr_en = 1'b1;
    od_index = idx;
    od_sub = sb;
    od_wdata = d;
    @(posedge clk_sys);
    #1;
    od_wr_en = 1'b0;
  endtask

  task automatic od_rd(input logic [15:0] idx, input logic [7:0] sb);
    @(posedge clk_sys);
    #1;
    od_rd_en = 1'b1;
    od_index = idx;
    od_sub = sb;
    @(posedge clk_sys);
    #1;
    od_rd_en = 1'b0;
    `TB_CHK("rvalid", 1'b1, od_rvalid)
    got = od_rdata;
  endtask

  // The axis is parked at 100 before every start so each run has a known origin.
  task automatic run(input logic [7:0] m);
    od_wr(`AHS_IDX_CTRL, 8'h00, 32'h0000_0000);
    ld = 1'b1;
    od_wr(`AHS_IDX_METHOD, 8'h00, {24'h00_0000, m});
    ld = 1'b0;
    od_wr(`AHS_IDX_CTRL, 8'h00, 32'h0000_0010);
  endtask

  task automatic wait_done;
    for (int i = 0; i < 2000; i++)
    begin
      if (statusword[12] === 1'b1 || statusword[13] === 1'b1)
        break;
      if (move_en === 1'b1)
        last_spd = speed_cmd;
      @(posedge clk_sys);
      #1;
    end
  endtask

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // A hang is cut short well beyond the longest run of all tests.
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      $display("unexpected timeout exp 0 got %0d", cyc);
      results();
    end
  end

  // ****************
  // Test sequence
  // ****************
  initial
  begin
    repeat (12) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    `TB_CHK("status_rst", 16'h0000, statusword)
    for (int i = 0; i < 8; i++)
    begin
      od_rd(r_idx[i], r_sub[i]);
      `TB_CHK("reg_rst", (i == 0) ? 32'h0000_0002 : 32'h0000_0000, got)
    end
    for (int i = 0; i < 8; i++)
      od_wr(r_idx[i], r_sub[i], w_val[i]);
    for (int i = 0; i < 8; i++)
    begin
      od_rd(r_idx[i], r_sub[i]);
      `TB_CHK("reg_rw", r_new[i], got)
    end
    $display("test registers done");
    // Methods 3 and 13 cover the home switch, including a limit reversal on the way.
    for (int i = 0; i < 9; i++)
    begin
      run(m_code[i]);
      `TB_CHK("move_on", m_code[i] != 8'h23, move_en)
      if (m_code[i] != 8'h23)
        `TB_CHK("dir", m_dir[i], dir_right)
      `TB_CHK("accel", 32'h0000_1234, accel_cmd)
      if (m_last[i] != 0)
        `TB_CHK("spd_first", 32'h0000_0064, speed_cmd)
      wait_done();
      `TB_CHK("attained", 1'b1, statusword[12])
      `TB_CHK("home", m_home[i], home_pos)
      `TB_CHK("zero", m_home[i] + 32'hFFFF_FFFB, zero_pos)
      if (m_last[i] != 0)
        `TB_CHK("spd_last", m_last[i], last_spd)
      $display("test method %0h done", m_code[i]);
    end
    foreach (m_bad[i])
    begin
      run(m_bad[i]);
      `TB_CHK("err", 2'b10, statusword[13:12])
      `TB_CHK("still", 1'b0, move_en)
    end
    run(8'h00);
    `TB_CHK("none", 3'b000, {statusword[13:12], move_en})
    $display("test refused codes done");
    run(8'h21);
    od_wr(`AHS_IDX_CTRL, 8'h00, 32'h0000_0110);
    `TB_CHK("halt", 1'b0, move_en)
    `TB_CHK("reached", 1'b1, statusword[10])
    od_wr(`AHS_IDX_CTRL, 8'h00, 32'h0000_0010);
    `TB_CHK("resume", 2'b10, {move_en, dir_right})
    od_wr(`AHS_IDX_CTRL, 8'h00, 32'h0000_0000);
    `TB_CHK("abort", 2'b00, {move_en, statusword[12]})
    $display("test halt and abort done");
    results();
  end
endmodule
